// >>> pqu_product_quotient_unit.sv
/*
 Product/quotient unit: radix-4 booth 32x16 multiplier, result register pair,
 iterative divider with early exit, and the issue interlock.
 Assumes the integer pipeline holds i_issue steady while o_stall is high.
*/
`timescale 1ns/10ps
module pqu_product_quotient_unit (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_issue_valid,
   input wire pqu_pkg::pqu_issue_s i_issue,
   input wire logic [pqu_pkg::DATA_W-1:0] i_first_source_operand,
   input wire logic [pqu_pkg::DATA_W-1:0] i_second_source_operand,
   output logic o_stall,
   output logic o_div_busy,
   output logic [pqu_pkg::DATA_W-1:0] o_upper_result_reg,
   output logic [pqu_pkg::DATA_W-1:0] o_lower_result_reg,
   output pqu_pkg::pqu_gpr_result_s o_gpr_result
);
   import pqu_pkg::*;

   function automatic logic signed [49:0] booth_mul(input logic signed [32:0] a, input logic [16:0] b);
      logic [18:0] bx;
      logic signed [49:0] ax;
      logic signed [49:0] pp;
      logic signed [49:0] acc;
      bx = {b[16], b, 1'b0};
      ax = a;
      acc = '0;
      for (int i = 0; i < 9; i++) begin
         case (bx[2*i+2 -: 3])
            3'b001, 3'b010: pp = ax;
            3'b011: pp = ax <<< 1;
            3'b100: pp = -(ax <<< 1);
            3'b101, 3'b110: pp = -ax;
            default: pp = '0;
         endcase
         acc = acc + (pp <<< (2 * i));
      end
      return acc;
   endfunction : booth_mul

   // One restoring step: shift {rem,quo}, trial subtract
   function automatic logic [63:0] div_step(input logic [63:0] rq, input logic [31:0] d);
      logic [32:0] part;
      logic [32:0] diff;
      part = rq[63:31];
      diff = part - {1'b0, d};
      if (part >= {1'b0, d}) begin
         return {diff[31:0], rq[30:0], 1'b1};
      end
      return {part[31:0], rq[30:0], 1'b0};
   endfunction : div_step

   logic [DATA_W-1:0] a;
   logic [DATA_W-1:0] b;
   logic sgn;
   logic short_b;
   logic is_mul;
   logic is_div;
   logic take;
   logic pass2_q, pass2_d;
   logic [32:0] ma_q, ma_d;
   logic [16:0] bhi_q, bhi_d;
   logic [PAIR_W-1:0] plo_q, plo_d;
   pqu_issue_s mop_q, mop_d;
   pqu_gpr_result_s gpr_q, gpr_d, gpr2_q;
   logic [32:0] mul_a;
   logic [16:0] mul_b;
   logic signed [49:0] prod;
   logic [PAIR_W-1:0] prod_x;
   logic [PAIR_W-1:0] fin;
   logic fin_valid;
   pqu_issue_s fin_op;
   logic [CNT_W-1:0] dcnt_q, dcnt_d;
   logic [CNT_W-1:0] dstep_q, dstep_d;
   logic [63:0] drq_q, drq_d;
   logic [DATA_W-1:0] ddiv_q, ddiv_d;
   logic qneg_q, qneg_d;
   logic rneg_q, rneg_d;
   logic div_busy;
   logic div_last;
   logic [63:0] drq_next;
   logic [PAIR_W-1:0] pair_q, pair_d;

   assign a = i_first_source_operand;
   assign b = i_second_source_operand;
   assign sgn = i_issue.is_signed;
   assign is_div = i_issue.op == PQU_OP_QUOTIENT;
   assign is_mul = !is_div;
   assign div_busy = dcnt_q != '0;
   assign div_last = dcnt_q == 6'h01;
   // width found by the unit itself
   assign short_b = sgn ? (&b[31:15] | ~|b[31:15]) : ~|b[31:16];
   // any issue waits out the divide
   assign o_stall = i_issue_valid & (div_busy | pass2_q);
   assign take = i_issue_valid & !o_stall;
   assign o_div_busy = div_busy;

   assign mul_a = pass2_q ? ma_q : {sgn & a[31], a};
   assign mul_b = pass2_q ? bhi_q : (short_b ? b[16:0] : {1'b0, b[15:0]});
   assign prod = booth_mul(mul_a, mul_b);
   assign prod_x = {{14{prod[49]}}, prod};
   assign fin = pass2_q ? plo_q + (prod_x << SLICE_W) : prod_x;
   assign fin_valid = pass2_q | (take & is_mul & short_b);
   assign fin_op = pass2_q ? mop_q : i_issue;

   always_comb begin
      pass2_d = take & is_mul & !short_b;
      ma_d = {sgn & a[31], a};
      bhi_d = {sgn & b[31], b[31:16]};
      plo_d = prod_x;
      mop_d = i_issue;
      gpr_d = '0;
      if (fin_valid && fin_op.op == PQU_OP_PRODUCT_TO_GPR) begin
         gpr_d.valid = 1'b1;
         gpr_d.dest = fin_op.dest;
         gpr_d.data = fin[DATA_W-1:0];
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         pass2_q <= 1'b0;
         ma_q <= '0;
         bhi_q <= '0;
         plo_q <= '0;
         mop_q <= '0;
         gpr_q <= '0;
         gpr2_q <= '0;
      end else begin
         pass2_q <= pass2_d;
         ma_q <= ma_d;
         bhi_q <= bhi_d;
         plo_q <= plo_d;
         mop_q <= mop_d;
         gpr_q <= gpr_d;
         gpr2_q <= gpr_q;
      end
   end
   assign o_gpr_result = gpr2_q;
   // no stall input; work always advances
   assign drq_next = (dstep_q != '0) ? div_step(drq_q, ddiv_q) : drq_q;

   always_comb begin
      logic [DATA_W-1:0] dmag;
      logic [CNT_W-1:0] skip;
      logic [CNT_W-1:0] rpt;
      dmag = (sgn & a[31]) ? DATA_W'(-a) : a;
      skip = DIV_SKIP_32;
      rpt = DIV_RPT_32;
      if (sgn ? (&a[31:7] | ~|a[31:7]) : ~|a[31:8]) begin
         skip = DIV_SKIP_8;
         rpt = DIV_RPT_8;
      end else if (sgn ? (&a[31:15] | ~|a[31:15]) : ~|a[31:16]) begin
         skip = DIV_SKIP_16;
         rpt = DIV_RPT_16;
      end else if (sgn ? (&a[31:23] | ~|a[31:23]) : ~|a[31:24]) begin
         skip = DIV_SKIP_24;
         rpt = DIV_RPT_24;
      end
      dcnt_d = div_busy ? dcnt_q - 6'h01 : '0;
      dstep_d = (dstep_q != '0) ? dstep_q - 6'h01 : '0;
      drq_d = drq_next;
      ddiv_d = ddiv_q;
      qneg_d = qneg_q;
      rneg_d = rneg_q;
      if (take && is_div) begin
         ddiv_d = (sgn & b[31]) ? DATA_W'(-b) : b;
         // first bit in the issue cycle
         drq_d = div_step({32'h0, dmag << skip}, ddiv_d);
         // busy for repeat rate less one
         dcnt_d = rpt - 6'h01;
         dstep_d = DIV_FULL_ITER - skip - 6'h01;
         qneg_d = sgn & (a[31] ^ b[31]);
         rneg_d = sgn & a[31];
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         dcnt_q <= '0;
         dstep_q <= '0;
         drq_q <= '0;
         ddiv_q <= '0;
         qneg_q <= 1'b0;
         rneg_q <= 1'b0;
      end else begin
         dcnt_q <= dcnt_d;
         dstep_q <= dstep_d;
         drq_q <= drq_d;
         ddiv_q <= ddiv_d;
         qneg_q <= qneg_d;
         rneg_q <= rneg_d;
      end
   end

   always_comb begin
      pair_d = pair_q;
      // pair written as a pair product completes or at the last divide step
      if (fin_valid) begin
         case (fin_op.op)
            PQU_OP_PRODUCT_TO_PAIR: pair_d = fin;
            PQU_OP_PRODUCT_ACCUMULATE: pair_d = pair_q + fin;
            PQU_OP_PRODUCT_SUBTRACT_ACCUMULATE: pair_d = pair_q - fin;
            default: pair_d = pair_q;
         endcase
      end else if (div_last) begin
         pair_d[63:32] = rneg_q ? DATA_W'(-drq_next[63:32]) : drq_next[63:32];
         pair_d[31:0] = qneg_q ? DATA_W'(-drq_next[31:0]) : drq_next[31:0];
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         pair_q <= '0;
      end else begin
         pair_q <= pair_d;
      end
   end
   assign o_upper_result_reg = pair_q[63:32];
   assign o_lower_result_reg = pair_q[31:0];

   // Reference values used only by the checks below
   logic signed [65:0] ref_prod;
   logic [PAIR_W-1:0] exp_q;
   logic dz_q;
   assign ref_prod = $signed({sgn & a[31], a}) * $signed({sgn & b[31], b});
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         exp_q <= '0;
         dz_q <= 1'b0;
      end else if (take && is_div) begin
         dz_q <= b == '0;
         if (b == '0) begin
            exp_q <= '0;
         end else if (sgn) begin
            exp_q <= {DATA_W'($signed(a) % $signed(b)), DATA_W'($signed(a) / $signed(b))};
         end else begin
            exp_q <= {a % b, a / b};
         end
      end
   end

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   sequence s_take_short(pqu_op_e o);
      take && is_mul && short_b && i_issue.op == o;
   endsequence
   sequence s_take_long(pqu_op_e o);
      take && is_mul && !short_b && i_issue.op == o;
   endsequence
   sequence s_div_start_32;
      take && is_div && (sgn ? !(&a[31:23] | ~|a[31:23]) : |a[31:24]);
   endsequence
   sequence s_div_start_8;
      take && is_div && (sgn ? (&a[31:7] | ~|a[31:7]) : ~|a[31:8]);
   endsequence

   AST_SHORT_PAIR: assert property (
      s_take_short(PQU_OP_PRODUCT_TO_PAIR) |=> pair_q == $past(ref_prod[63:0]))
      else $error("short pair product wrong or late");
   AST_LONG_PAIR: assert property (
      s_take_long(PQU_OP_PRODUCT_TO_PAIR) |=> ##1 pair_q == $past(ref_prod[63:0], 2))
      else $error("long pair product wrong or late");
   AST_GPR_SHORT: assert property (
      s_take_short(PQU_OP_PRODUCT_TO_GPR) |-> ##2 (o_gpr_result.valid && o_gpr_result.data == $past(ref_prod[31:0], 2)))
      else $error("short register product wrong or late");
   AST_GPR_LONG: assert property (
      s_take_long(PQU_OP_PRODUCT_TO_GPR) |-> ##2 !o_gpr_result.valid ##1 (o_gpr_result.valid && o_gpr_result.data == $past(ref_prod[31:0], 3)))
      else $error("long register product wrong or late");
   AST_LONG_INTERLOCK: assert property (
      take && is_mul && !short_b |=> (i_issue_valid == o_stall) ##1 !pass2_q)
      else $error("long multiply interlock wrong");
   AST_SHORT_EVERY_CYCLE: assert property (
      !div_busy && !pass2_q |-> !o_stall)
      else $error("idle unit stalled issue");
   AST_DIV_STALL: assert property (
      i_issue_valid && div_busy |-> o_stall)
      else $error("issue accepted during divide");
   AST_DIV_TIME_32: assert property (
      s_div_start_32 |-> ##1 (div_busy throughout (1'b1 ##29 1'b1)) ##1 div_last ##1 !div_busy)
      else $error("full divide timing wrong");
   AST_DIV_TIME_8: assert property (
      s_div_start_8 |-> ##10 div_last ##1 !div_busy)
      else $error("short divide early exit wrong");
   AST_DIV_RESULT: assert property (
      div_last && !dz_q |=> pair_q == exp_q)
      else $error("divide result wrong");
endmodule : pqu_product_quotient_unit

// >>> pqu_pkg.sv
/*
 Shared constants and types of the product/quotient unit: operation codes,
 issue and result carriers, divide early-exit counts and pipeline latencies.
 Assumes one pipeline clock and a synchronous reset in the core.
*/
package pqu_pkg;
   localparam int DATA_W = 32;
   localparam int PAIR_W = 64;
   localparam int SLICE_W = 16;
   localparam int GPR_IDX_W = 5;
   localparam int CNT_W = 6;
   // Early-exit iterations skipped per dividend width
   localparam logic [CNT_W-1:0] DIV_SKIP_8 = 6'h17;
   localparam logic [CNT_W-1:0] DIV_SKIP_16 = 6'h0F;
   localparam logic [CNT_W-1:0] DIV_SKIP_24 = 6'h07;
   localparam logic [CNT_W-1:0] DIV_SKIP_32 = 6'h00;
   localparam logic [CNT_W-1:0] DIV_FULL_ITER = 6'h20;
   // Divide repeat rates in clocks; latency is the same
   localparam logic [CNT_W-1:0] DIV_RPT_8 = 6'h0B;
   localparam logic [CNT_W-1:0] DIV_RPT_16 = 6'h12;
   localparam logic [CNT_W-1:0] DIV_RPT_24 = 6'h19;
   localparam logic [CNT_W-1:0] DIV_RPT_32 = 6'h20;
   localparam int MUL_PAIR_LAT_SHORT = 1;
   localparam int MUL_PAIR_LAT_LONG = 2;
   localparam int MUL_GPR_LAT_SHORT = 2;
   localparam int MUL_GPR_LAT_LONG = 3;

   typedef enum logic [2:0] {
      PQU_OP_PRODUCT_TO_PAIR = 3'h0,
      PQU_OP_PRODUCT_ACCUMULATE = 3'h1,
      PQU_OP_PRODUCT_SUBTRACT_ACCUMULATE = 3'h2,
      PQU_OP_PRODUCT_TO_GPR = 3'h3,
      PQU_OP_QUOTIENT = 3'h4
   } pqu_op_e;

   typedef struct packed {
      pqu_op_e op;
      logic is_signed;
      logic [GPR_IDX_W-1:0] dest;
   } pqu_issue_s;

   typedef struct packed {
      logic valid;
      logic [GPR_IDX_W-1:0] dest;
      logic [DATA_W-1:0] data;
   } pqu_gpr_result_s;
endpackage : pqu_pkg

// >>> pqu_pipe_model.sv
/*
 Integer-pipeline issue model for the product/quotient unit.
 Assumes o_stall settles within one ns after the falling clock edge.
*/
`timescale 1ns/10ps
module pqu_pipe_model (
   input wire logic i_clock,
   input wire logic i_stall,
   output logic o_valid,
   output pqu_pkg::pqu_issue_s o_issue,
   output logic [pqu_pkg::DATA_W-1:0] o_first,
   output logic [pqu_pkg::DATA_W-1:0] o_second
);
   import pqu_pkg::*;

   initial begin
      o_valid = 1'h0;
      o_issue = '0;
      o_first = 32'h0;
      o_second = 32'h0;
   end

   // Holds the request until an edge without stall
   task automatic put(input pqu_issue_s iss, input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b,
                      output int waits);
      logic s;
      waits = 0;
      @(negedge i_clock);
      o_valid = 1'h1;
      o_issue = iss;
      o_first = a;
      o_second = b;
      forever begin
         #1;
         s = i_stall;
         @(posedge i_clock);
         if (!s) break;
         waits++;
         @(negedge i_clock);
      end
   endtask : put

   // Released operands never show the last value
   task automatic idle();
      @(negedge i_clock);
      o_valid = 1'h0;
      o_first = ~o_first;
      o_second = ~o_second;
   endtask : idle
endmodule : pqu_pipe_model

// >>> tb_top.sv
/*
 Self-checking bench of the product/quotient unit with a reference model.
 Assumes the issue model in pqu_pipe_model and the unit's package.
*/
`timescale 1ns/10ps
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin miscompares++; $display("ERROR %0t %s", $time, m); end end
module tb_top;
   import pqu_pkg::*;
   logic i_clock = 1'h0;
   logic i_rst = 1'h1;
   logic iv;
   logic stall;
   logic busy;
   pqu_issue_s iss;
   logic [31:0] fa;
   logic [31:0] sb;
   logic [31:0] up;
   logic [31:0] lo;
   pqu_gpr_result_s gr;
   int miscompares = 0;
   int n_checks = 0;
   int prev_wait = 0;
   int rpt[4] = '{11, 18, 25, 32};
   logic [63:0] pair_m = 64'h0;

   always #25 i_clock = ~i_clock;

   pqu_pipe_model i_pipe (.i_clock(i_clock), .i_stall(stall), .o_valid(iv), .o_issue(iss),
      .o_first(fa), .o_second(sb));
   pqu_product_quotient_unit i_dut (.i_clock(i_clock), .i_rst(i_rst), .i_issue_valid(iv), .i_issue(iss),
      .i_first_source_operand(fa), .i_second_source_operand(sb), .o_stall(stall), .o_div_busy(busy),
      .o_upper_result_reg(up), .o_lower_result_reg(lo), .o_gpr_result(gr));

   function automatic logic [63:0] ext(input logic [31:0] v, input logic sg);
      return sg ? {{32{v[31]}}, v} : {32'h0, v};
   endfunction : ext

   function automatic logic fits(input logic [31:0] v, input logic sg, input int w);
      logic [31:0] m;
      m = 32'hFFFFFFFF << w;
      return (v & m) == ((sg && v[w-1]) ? m : 32'h0);
   endfunction : fits

   function automatic logic [31:0] val(input logic sg, input int w);
      logic [31:0] m;
      logic [31:0] v;
      m = 32'hFFFFFFFF << w;
      v = $urandom;
      return (v & ~m) | ((sg && v[w-1]) ? m : 32'h0);
   endfunction : val

   task automatic chk_pair(input int lat, input logic [63:0] e);
      repeat (lat) @(negedge i_clock);
      `CHK({up, lo}, e, "result pair")
   endtask : chk_pair

   task automatic chk_gpr(input int lat, input logic [4:0] d, input logic [31:0] e);
      repeat (lat) @(negedge i_clock);
      `CHK(gr, pqu_gpr_result_s'({1'h1, d, e}), "register result")
   endtask : chk_gpr

   task automatic chk_div(input int r, input logic [63:0] e);
      repeat (r - 1) @(negedge i_clock);
      `CHK(busy, 1'h1, "divide busy")
      @(negedge i_clock);
      `CHK(busy, 1'h0, "divide idle")
      `CHK({up, lo}, e, "divide result")
   endtask : chk_div

   task automatic run(input pqu_op_e op, input logic sg, input int w);
      pqu_issue_s is;
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] q;
      logic [31:0] rm;
      logic [63:0] p;
      int waits;
      int lat;
      int r;
      is.op = op;
      is.is_signed = sg;
      is.dest = 5'($urandom);
      a = val(sg, (op == PQU_OP_QUOTIENT) ? 8 * (w + 1) : 32);
      b = val(sg, (op != PQU_OP_QUOTIENT && w % 2 == 0) ? 16 : 32);
      if (op == PQU_OP_QUOTIENT) b[1:0] = 2'h1;
      i_pipe.put(is, a, b, waits);
      `CHK(waits, prev_wait, "issue stall count")
      p = ext(a, sg) * ext(b, sg);
      lat = fits(b, sg, 16) ? 1 : 2;
      prev_wait = lat - 1;
      case (op)
         PQU_OP_QUOTIENT: begin
            for (int k = 3; k >= 0; k--) if (fits(a, sg, 8 * (k + 1))) r = rpt[k];
            if (sg) begin
               q = $signed(a) / $signed(b);
               rm = $signed(a) % $signed(b);
            end else begin
               q = a / b;
               rm = a % b;
            end
            pair_m = {rm, q};
            prev_wait = r - 1;
            fork chk_div(r, pair_m); join_none
         end
         PQU_OP_PRODUCT_TO_GPR: begin
            fork chk_gpr(lat + 1, is.dest, p[31:0]); join_none
         end
         default: begin
            pair_m = (op == PQU_OP_PRODUCT_ACCUMULATE) ? pair_m + p :
                     (op == PQU_OP_PRODUCT_SUBTRACT_ACCUMULATE) ? pair_m - p : p;
            fork chk_pair(lat, pair_m); join_none
         end
      endcase
   endtask : run

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : print_verdict

   initial begin
      void'($urandom(32'h50030ee5));
      repeat (16) @(negedge i_clock);
      i_rst = 1'h0;
      `CHK({up, lo, busy, gr.valid}, 66'h0, "reset state")
      $display("test reset done");
      for (int op = 0; op < 5; op++) begin
         for (int sg = 0; sg < 2; sg++) begin
            for (int w = 0; w < 4; w++) run(pqu_op_e'(op), sg[0], w);
         end
      end
      $display("test sweep done");
      repeat (60) run(pqu_op_e'(3'($urandom_range(4, 0))), 1'($urandom), $urandom_range(3, 0));
      i_pipe.idle();
      repeat (40) @(negedge i_clock);
      $display("test random done");
      print_verdict();
   end

   // Cuts a hang short
   initial begin
      #(50 * 12000);
      miscompares++;
      $display("ERROR %0t watchdog expired", $time);
      print_verdict();
   end
endmodule : tb_top
